/* common/cme_pkg.sv */
// Constants and types for the core memory read-write controller.
// Assumes a single 40 MHz clock and a synchronous active-low reset.
package cme_pkg;
  // Clock period and documented times, in ns
  localparam int CLK_NS = 25;
  localparam int S_CYC_NS = 6400;
  localparam int S_ACC_NS = 4000;
  localparam int T_CYC_NS = 4400;
  localparam int T_ACC_NS = 2000;
  localparam int V_ACC_NS = 1000;
  localparam int STB_NS = 100;
  // Cycle counts derived from the times above
  localparam logic [8:0] S_CYC = 9'(S_CYC_NS / CLK_NS);
  localparam logic [8:0] S_ACC = 9'(S_ACC_NS / CLK_NS);
  localparam logic [8:0] T_CYC = 9'(T_CYC_NS / CLK_NS);
  localparam logic [8:0] T_ACC = 9'(T_ACC_NS / CLK_NS);
  localparam logic [8:0] V_ACC = 9'(V_ACC_NS / CLK_NS);
  localparam logic [8:0] STB_CYC = 9'((STB_NS + CLK_NS - 1) / CLK_NS);
  // Grid-to-regulator lead and inhibit-before-write lead, in cycles
  localparam logic [1:0] GRID_LEAD = 2'h2;
  localparam logic [8:0] INH_LEAD = 9'h004;
  // Word widths and layout
  localparam int W = 38;
  localparam int FF_W = 36;
  localparam int ST_W = 37;
  localparam int QUARTERS = 4;
  localparam int VSEL_HI = 6;
  localparam int VSEL_LO = 4;
  localparam logic [2:0] FF_XH_IDX = 3'h4;
  localparam logic [1:0] FF_LAST_ARITH = 2'h3;
  typedef enum logic [1:0] {
    CME_MEM_S = 2'b00,
    CME_MEM_T = 2'b01,
    CME_MEM_U = 2'b10,
    CME_MEM_V = 2'b11
  } cme_mem_t;
  typedef enum logic [2:0] {
    CME_IDLE = 3'b000,
    CME_CORE = 3'b001,
    CME_FF_RD = 3'b010,
    CME_FF_WR = 3'b011,
    CME_VST = 3'b100
  } cme_state_t;
endpackage : cme_pkg

/* rtl/cme_drv_group.sv */
// One 16-line switch driver group: eight grid lines, two regulators.
// Assumes sel is a level from the sequencer on the same clock.
`timescale 1ns/100ps
module cme_drv_group
  import cme_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] line,
  input wire logic sel,
  output logic [7:0] grid_r,
  output logic [1:0] reg_r
);
  logic [1:0] lead_r;

  // Count how long the grid has been held before pulsing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lead_r <= 2'h0;
    end else if (!sel) begin
      lead_r <= 2'h0;
    end else if (lead_r != GRID_LEAD) begin
      lead_r <= lead_r + 2'h1;
    end
  end

  // Grid held one cycle past the regulator so the pulse ends cleanly
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      grid_r <= 8'h00;
    end else begin
      grid_r <= (sel || |reg_r) ? 8'h01 << line[2:0] : 8'h00;
    end
  end

  // Regulator 0 serves lines 0-7, regulator 1 lines 8-15
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_r <= 2'h0;
    end else if (sel && lead_r == GRID_LEAD) begin
      reg_r <= line[3] ? 2'b10 : 2'b01;
    end else begin
      reg_r <= 2'h0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_grid_first: assert property ($rose(|reg_r) |-> $past(|grid_r, 2))
    else $error("regulator pulsed before grid");
  a_line_map: assert property (|reg_r |->
    reg_r[$past(line[3])] && grid_r[$past(line[2:0])])
    else $error("wrong grid or regulator for line");
endmodule : cme_drv_group

/* rtl/cme_sense.sv */
// Pin synchroniser and section merge for sense or digit outputs.
// Assumes asynchronous pin levels; NSEC sections make one bit.
`timescale 1ns/100ps
module cme_sense
  import cme_pkg::*;
#(
  parameter int BITS = W,
  parameter int NSEC = QUARTERS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [BITS*NSEC-1:0] sec,
  output logic [BITS-1:0] bit_r
);
  logic [BITS*NSEC-1:0] m1_r;
  logic [BITS*NSEC-1:0] m2_r;
  logic [BITS-1:0] or_v;

  // Two-flop synchroniser; only m2_r is looked at
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      m1_r <= '0;
      m2_r <= '0;
    end else begin
      m1_r <= sec;
      m2_r <= m1_r;
    end
  end

  // Any section high makes the bit a one
  always_comb begin
    for (int b = 0; b < BITS; b++) begin
      or_v[b] = |m2_r[b*NSEC +: NSEC];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_r <= '0;
    end else begin
      bit_r <= or_v;
    end
  end
endmodule : cme_sense

/* rtl/cme_ctrl.sv */
// Read-write control for the core and register memories.
// Assumes the control element issues one request at a time on clk.
`timescale 1ns/100ps
module cme_ctrl
  import cme_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic store,
  input wire cme_mem_t mem_sel,
  input wire logic [15:0] addr,
  input wire logic [W-1:0] wdata,
  output logic busy_r,
  output logic done_r,
  output logic parity_skip_r,
  output logic [W-1:0] memory_buffer_reg,
  output logic [FF_W-1:0] operand_reg,
  output logic [7:0] x_first_drive_grid,
  output logic [1:0] x_first_drive_reg,
  output logic [7:0] x_second_drive_grid,
  output logic [1:0] x_second_drive_reg,
  output logic [7:0] y_first_drive_grid,
  output logic [1:0] y_first_drive_reg,
  output logic [7:0] y_second_drive_grid,
  output logic [1:0] y_second_drive_reg,
  output logic [QUARTERS*W-1:0] s_inhibit_r,
  input wire logic [QUARTERS*W-1:0] s_sense,
  output logic [63:0] t_x_sel_r,
  output logic [63:0] t_y_sel_r,
  output logic t_bank_u_r,
  output logic t_read_r,
  output logic t_write_r,
  output logic [W-1:0] t_inhibit_r,
  input wire logic [W-1:0] t_sense,
  output logic [8:0] static_addr_r,
  output logic static_rd_r,
  input wire logic [ST_W-1:0] static_data
);
  cme_state_t st_r;
  cme_mem_t mem_r;
  logic [15:0] addr_r;
  logic store_r;
  logic [W-1:0] wdata_r;
  logic [8:0] cnt_r;
  logic [1:0] step_r;
  logic [8:0] cyc_len;
  logic [8:0] acc_len;
  logic strobe_r;
  logic wr_time_r;
  logic s_sel;
  logic tu;
  logic [W-1:0] s_bits;
  logic [W-1:0] t_bits;
  logic [ST_W-1:0] v_bits;
  logic [W-1:0] sensed;
  logic [FF_W-1:0] arith_r [0:3];
  logic [FF_W-1:0] exchange_hold_reg;
  logic [2:0] ff_idx;
  logic [1:0] quad;
  logic [7:0] lv1x, lv2x, lv1y, lv2y;
  logic [63:0] t_x_nxt, t_y_nxt;

  // Per-memory timing; the reserved memory shares the small one's
  always_comb begin
    unique case (mem_r)
      CME_MEM_S: begin
        cyc_len = S_CYC;
        acc_len = S_ACC;
      end
      CME_MEM_T, CME_MEM_U: begin
        cyc_len = T_CYC;
        acc_len = T_ACC;
      end
      CME_MEM_V: begin
        cyc_len = V_ACC;
        acc_len = V_ACC;
      end
    endcase
  end

  assign tu = (mem_r == CME_MEM_T) || (mem_r == CME_MEM_U);
  assign ff_idx = addr_r[2:0];
  assign quad = {addr_r[15], addr_r[7]};

  // Request intake; requests outside the idle state are ignored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_r <= CME_MEM_S;
      addr_r <= 16'h0000;
      store_r <= 1'b0;
      wdata_r <= '0;
    end else if (req && st_r == CME_IDLE) begin
      mem_r <= mem_sel;
      addr_r <= addr;
      store_r <= store;
      wdata_r <= wdata;
    end
  end

  // Main sequencer: core cycles by count, register section by steps
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= CME_IDLE;
      cnt_r <= 9'h000;
      step_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 9'h001;
      unique case (st_r)
        CME_IDLE: begin
          cnt_r <= 9'h000;
          step_r <= 2'h0;
          if (req && mem_sel != CME_MEM_V) begin
            st_r <= CME_CORE;
          end else if (req && addr[VSEL_HI:VSEL_LO] == 3'h0) begin
            st_r <= CME_FF_RD;
          end else if (req) begin
            st_r <= CME_VST;
          end
        end
        CME_CORE, CME_VST: begin
          if (cnt_r == cyc_len - 9'h001) begin
            st_r <= CME_IDLE;
          end
        end
        CME_FF_RD: begin
          step_r <= step_r + 2'h1;
          if (step_r == 2'h2) begin
            step_r <= 2'h0;
            st_r <= store_r ? CME_FF_WR : CME_IDLE;
          end
        end
        CME_FF_WR: begin
          step_r <= step_r + 2'h1;
          if (step_r == 2'h3) begin
            st_r <= CME_IDLE;
          end
        end
        default: st_r <= CME_IDLE;
      endcase
    end
  end

  // Busy and one-cycle done flag toward the control element
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      parity_skip_r <= 1'b0;
    end else begin
      done_r <= busy_r && st_r == CME_IDLE;
      busy_r <= (st_r != CME_IDLE) || req;
      // A request taken in the closing cycle keeps busy up: set wins
      if (busy_r && st_r == CME_IDLE && !req) begin
        busy_r <= 1'b0;
      end
      if (req && st_r == CME_IDLE) begin
        parity_skip_r <= mem_sel == CME_MEM_V;
      end
    end
  end

  // Strobe sits just before access; write timing from access to end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strobe_r <= 1'b0;
      wr_time_r <= 1'b0;
    end else begin
      strobe_r <= (st_r == CME_CORE || st_r == CME_VST)
        && cnt_r >= acc_len - STB_CYC - 9'h001
        && cnt_r < acc_len - 9'h001;
      wr_time_r <= st_r == CME_CORE && cnt_r >= acc_len
        && cnt_r < cyc_len - 9'h001;
    end
  end

  // Sense and static data pins, synchronised and merged
  cme_sense #(.BITS(W), .NSEC(QUARTERS)) u_s_sense (
    .clk(clk), .rst_n(rst_n), .sec(s_sense), .bit_r(s_bits));
  cme_sense #(.BITS(W), .NSEC(1)) u_t_sense (
    .clk(clk), .rst_n(rst_n), .sec(t_sense), .bit_r(t_bits));
  cme_sense #(.BITS(ST_W), .NSEC(1)) u_v_sense (
    .clk(clk), .rst_n(rst_n), .sec(static_data), .bit_r(v_bits));

  always_comb begin
    unique case (mem_r)
      CME_MEM_S: sensed = s_bits;
      CME_MEM_T, CME_MEM_U: sensed = t_bits;
      CME_MEM_V: sensed = {1'b0, v_bits};
    endcase
  end

  // Buffer, exchange and arithmetic registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memory_buffer_reg <= '0;
      exchange_hold_reg <= '0;
      operand_reg <= '0;
      for (int i = 0; i < 4; i++) begin
        arith_r[i] <= '0;
      end
    end else if (req && st_r == CME_IDLE && mem_sel != CME_MEM_V) begin
      memory_buffer_reg <= '0; // Core cells read as zero unless sensed
    end else if (st_r == CME_CORE || st_r == CME_VST) begin
      if (strobe_r) begin
        memory_buffer_reg <= memory_buffer_reg | sensed;
      end
      if (st_r == CME_VST && cnt_r == 9'h000) begin
        memory_buffer_reg <= '0;
      end
      if (st_r == CME_CORE && cnt_r == acc_len && store_r) begin
        memory_buffer_reg <= wdata_r; // New word replaces the readout
      end
    end else if (st_r == CME_FF_RD) begin
      unique case (step_r)
        2'h0: memory_buffer_reg <= {2'b00, exchange_hold_reg};
        2'h1: begin
          if (ff_idx == FF_XH_IDX) begin
            exchange_hold_reg <= exchange_hold_reg;
          end else if (ff_idx[1:0] <= FF_LAST_ARITH && !ff_idx[2]) begin
            exchange_hold_reg <= arith_r[ff_idx[1:0]];
          end else begin
            exchange_hold_reg <= '0;
          end
        end
        2'h2: begin
          operand_reg <= exchange_hold_reg;
          exchange_hold_reg <= memory_buffer_reg[FF_W-1:0];
        end
        default: ;
      endcase
    end else if (st_r == CME_FF_WR) begin
      unique case (step_r)
        2'h0: memory_buffer_reg <= wdata_r;
        2'h1: exchange_hold_reg <= memory_buffer_reg[FF_W-1:0];
        2'h2: begin
          if (!ff_idx[2]) begin
            arith_r[ff_idx[1:0]] <= '0;
          end
        end
        2'h3: begin
          if (!ff_idx[2]) begin
            arith_r[ff_idx[1:0]] <= exchange_hold_reg;
          end
        end
      endcase
    end
  end

  // Large core: four 16-line driver groups on the two switches
  assign s_sel = st_r == CME_CORE && mem_r == CME_MEM_S
    && cnt_r < acc_len + INH_LEAD;
  cme_drv_group u_xf (.clk(clk), .rst_n(rst_n), .line(addr_r[7:4]),
    .sel(s_sel), .grid_r(x_first_drive_grid), .reg_r(x_first_drive_reg));
  cme_drv_group u_xs (.clk(clk), .rst_n(rst_n), .line(addr_r[3:0]),
    .sel(s_sel), .grid_r(x_second_drive_grid), .reg_r(x_second_drive_reg));
  cme_drv_group u_yf (.clk(clk), .rst_n(rst_n), .line(addr_r[15:12]),
    .sel(s_sel), .grid_r(y_first_drive_grid), .reg_r(y_first_drive_reg));
  cme_drv_group u_ys (.clk(clk), .rst_n(rst_n), .line(addr_r[11:8]),
    .sel(s_sel), .grid_r(y_second_drive_grid), .reg_r(y_second_drive_reg));

  // Inhibit per plane quarter on the large core, per plane on the small; zeros keep their cores from switching
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_inhibit_r <= '0;
      t_inhibit_r <= '0;
    end else begin
      for (int b = 0; b < W; b++) begin
        for (int q = 0; q < QUARTERS; q++) begin
          s_inhibit_r[b*QUARTERS+q] <= wr_time_r && mem_r == CME_MEM_S
            && quad == 2'(q) && !memory_buffer_reg[b];
        end
      end
      t_inhibit_r <= (wr_time_r && tu) ? ~memory_buffer_reg : '0;
    end
  end

  // Small core two-level decode: 8 x 8 levels onto 64 drivers
  assign lv1x = 8'h01 << addr_r[5:3];
  assign lv2x = 8'h01 << addr_r[2:0];
  assign lv1y = 8'h01 << addr_r[11:9];
  assign lv2y = 8'h01 << addr_r[8:6];
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      t_x_nxt[i] = lv1x[i/8] && lv2x[i%8];
      t_y_nxt[i] = lv1y[i/8] && lv2y[i%8];
    end
  end

  // Half-current read then write with inhibit on the small core
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      t_x_sel_r <= 64'h0;
      t_y_sel_r <= 64'h0;
      t_bank_u_r <= 1'b0;
      t_read_r <= 1'b0;
      t_write_r <= 1'b0;
    end else begin
      t_x_sel_r <= (st_r == CME_CORE && tu) ? t_x_nxt : 64'h0;
      t_y_sel_r <= (st_r == CME_CORE && tu) ? t_y_nxt : 64'h0;
      t_bank_u_r <= st_r == CME_CORE && mem_r == CME_MEM_U;
      t_read_r <= st_r == CME_CORE && tu && cnt_r < acc_len;
      t_write_r <= st_r == CME_CORE && tu
        && cnt_r >= acc_len + INH_LEAD && cnt_r < cyc_len - 9'h001;
    end
  end

  // Static section word select, read level held to access time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      static_addr_r <= 9'h000;
      static_rd_r <= 1'b0;
    end else begin
      static_addr_r <= addr_r[8:0];
      static_rd_r <= st_r == CME_VST && cnt_r < acc_len - 9'h001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_one_core: assert property (|x_first_drive_reg |->
    $onehot(x_first_drive_grid) && $onehot(y_second_drive_grid))
    else $error("switch select not one core");
  a_uv_together: assert property (|x_first_drive_reg ==
    |x_second_drive_reg) else $error("U and V drives apart");
  a_write_after: assert property ($fell(|x_first_drive_reg)
    |-> wr_time_r) else $error("drives ended outside write time");
  a_inhibit_zero: assert property (wr_time_r && tu
    |=> t_inhibit_r == ~$past(memory_buffer_reg))
    else $error("inhibit does not match zeros");
  a_quarter_gate: assert property (|s_inhibit_r |->
    $past(wr_time_r)) else $error("inhibit outside write time");
  a_strobe_len: assert property ($rose(strobe_r) |->
    strobe_r [*4] ##1 !strobe_r) else $error("strobe width wrong");
  a_restore: assert property (wr_time_r && !store_r
    |-> $stable(memory_buffer_reg)) else $error("readout not restored");
  a_t_cycle: assert property ($rose(busy_r) && mem_r == CME_MEM_T
    |-> ##76 strobe_r ##101 done_r) else $error("small core timing");
  a_t_decode: assert property (t_read_r |->
    $onehot(t_x_sel_r) && $onehot(t_y_sel_r)) else $error("bad decode");
  a_u_bank: assert property (t_read_r && mem_r == CME_MEM_U
    |-> t_bank_u_r) else $error("reserved bank not selected");
  a_ff_pick: assert property (req && st_r == CME_IDLE
    && mem_sel == CME_MEM_V && addr[6:4] == 3'h0 |=> st_r == CME_FF_RD)
    else $error("register section not picked");
  a_no_wr_load: assert property (st_r == CME_FF_RD && !store_r
    |=> st_r != CME_FF_WR) else $error("write without store");
  a_ff_swap: assert property (st_r == CME_FF_RD && step_r == 2'h2
    |=> operand_reg == $past(exchange_hold_reg)
    && exchange_hold_reg == $past(memory_buffer_reg[FF_W-1:0]))
    else $error("read swap wrong");
  a_ff_load: assert property (st_r == CME_FF_WR && step_r == 2'h2
    && !ff_idx[2] |=> arith_r[ff_idx[1:0]] == '0
    ##1 arith_r[ff_idx[1:0]] == $past(exchange_hold_reg))
    else $error("write order wrong");
  c_s_cycle: cover property ($rose(busy_r) && mem_r == CME_MEM_S);
  c_t_store: cover property (t_write_r && store_r);
  c_ff_write: cover property (st_r == CME_FF_WR);
  c_static: cover property (static_rd_r ##1 strobe_r);
endmodule : cme_ctrl

/* sim/cme_far_model.sv */
// Far-side model: core arrays behind the drivers and the static word pins.
// Assumes the controller's outputs are registers on clk.
`timescale 1ns/100ps
module cme_far_model
  import cme_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] xf_grid,
  input wire logic [1:0] xf_reg,
  input wire logic [7:0] xs_grid,
  input wire logic [1:0] xs_reg,
  input wire logic [7:0] yf_grid,
  input wire logic [1:0] yf_reg,
  input wire logic [7:0] ys_grid,
  input wire logic [1:0] ys_reg,
  input wire logic [QUARTERS*W-1:0] s_inhibit,
  output logic [QUARTERS*W-1:0] s_sense,
  input wire logic [63:0] t_x_sel,
  input wire logic [63:0] t_y_sel,
  input wire logic t_bank_u,
  input wire logic t_read,
  input wire logic t_write,
  input wire logic [W-1:0] t_inhibit,
  output logic [W-1:0] t_sense,
  input wire logic [8:0] static_addr,
  input wire logic static_rd,
  output logic [ST_W-1:0] static_data
);
  logic [W-1:0] smem [logic [15:0]];
  logic [W-1:0] tmem [logic [12:0]];
  logic sact, sact_q, trd_q, twr_q, tog;
  logic [15:0] skey;
  logic [12:0] tkey;
  logic [W-1:0] w;
  logic [QUARTERS*W-1:0] sinh_q;
  logic [W-1:0] tinh_q;
  integer b;

  // Line number from one grid line plus the regulator half
  function automatic logic [3:0] lidx(input logic [7:0] g,
                                      input logic [1:0] r);
    logic [3:0] v;
    v = {r[1], 3'h0};
    for (int i = 0; i < 8; i++) if (g[i]) v[2:0] = 3'(i);
    return v;
  endfunction : lidx

  function automatic logic [5:0] tidx(input logic [63:0] s);
    logic [5:0] v;
    v = 6'h00;
    for (int i = 0; i < 64; i++) if (s[i]) v = 6'(i);
    return v;
  endfunction : tidx

  // A switch core moves only with all four drives present
  assign sact = (|xf_reg) && (|xs_reg) && (|yf_reg) && (|ys_reg);

  // Large array: read clears the word, end of drive writes ones
  initial s_sense = '0;
  always @(posedge clk) begin
    sact_q <= sact;
    if (sact && !sact_q) begin
      skey = {lidx(yf_grid, yf_reg), lidx(ys_grid, ys_reg),
              lidx(xf_grid, xf_reg), lidx(xs_grid, xs_reg)};
      w = smem.exists(skey) ? smem[skey] : '0;
      // Only the selected quarter carries the signal
      for (b = 0; b < W; b++) s_sense[b*4+{skey[15], skey[7]}] <= w[b];
      smem[skey] = '0;
    end
    if (sact) sinh_q <= s_inhibit;
    if (!sact && sact_q) begin
      // Inhibited planes stay zero
      for (b = 0; b < W; b++) w[b] = ~sinh_q[b*4+{skey[15], skey[7]}];
      smem[skey] = w;
      s_sense <= '0;
    end
  end

  // Small and reserved arrays share pins, bank bit splits them
  initial t_sense = '0;
  always @(posedge clk) begin
    trd_q <= t_read;
    twr_q <= t_write;
    if (t_read && !trd_q) begin
      tkey = {t_bank_u, tidx(t_y_sel), tidx(t_x_sel)};
      t_sense <= tmem.exists(tkey) ? tmem[tkey] : '0;
      tmem[tkey] = '0;
    end
    if (!t_read) t_sense <= '0;
    if (t_write) tinh_q <= t_inhibit;
    if (!t_write && twr_q) tmem[tkey] = ~tinh_q;
  end

  // Static words; unselected pins toggle so a stale value never passes
  initial tog = 1'b0;
  always @(posedge clk) tog <= ~tog;
  assign static_data = static_rd ?
    (ST_W'({4{static_addr}}) ^ 37'h05a5a5a5a5) : {ST_W{tog}};
endmodule : cme_far_model

/* sim/tb_cme_ctrl.sv */
// Self-checking bench for the core and register memory controller.
// Assumes the far-side model stands in for the arrays and static pins.
`timescale 1ns/100ps
module tb_cme_ctrl
  import cme_pkg::*;
();
  typedef struct {
    logic [1:0] kind;
    logic [W-1:0] val;
    logic [W-1:0] msk;
    logic pchk;
  } cme_note_t;
  localparam logic [1:0] KB = 2'h0, KO = 2'h1, KN = 2'h2;
  localparam logic [W-1:0] ALL = '1;
  localparam logic [W-1:0] SMSK = {1'b0, {ST_W{1'b1}}};
  logic clk, rst_n, req, store;
  cme_mem_t mem_sel;
  logic [15:0] addr, a;
  logic [W-1:0] wdata, d, d2, memory_buffer_reg;
  logic busy_r, done_r, parity_skip_r;
  logic [FF_W-1:0] operand_reg;
  logic [7:0] xfg, xsg, yfg, ysg;
  logic [1:0] xfr, xsr, yfr, ysr;
  logic [QUARTERS*W-1:0] s_inh, s_sen;
  logic [63:0] txs, tys;
  logic tbu, trd, twr;
  logic [W-1:0] t_inh, t_sen, rd [4];
  logic [8:0] st_a;
  logic st_rd;
  logic [ST_W-1:0] st_d;
  cme_note_t q [$];
  int fails, checked;
  integer seed = 32'h67459159;

  cme_ctrl uut (.clk(clk), .rst_n(rst_n), .req(req), .store(store),
    .mem_sel(mem_sel), .addr(addr), .wdata(wdata), .busy_r(busy_r),
    .done_r(done_r), .parity_skip_r(parity_skip_r),
    .memory_buffer_reg(memory_buffer_reg), .operand_reg(operand_reg),
    .x_first_drive_grid(xfg), .x_first_drive_reg(xfr),
    .x_second_drive_grid(xsg), .x_second_drive_reg(xsr),
    .y_first_drive_grid(yfg), .y_first_drive_reg(yfr),
    .y_second_drive_grid(ysg), .y_second_drive_reg(ysr),
    .s_inhibit_r(s_inh), .s_sense(s_sen), .t_x_sel_r(txs), .t_y_sel_r(tys),
    .t_bank_u_r(tbu), .t_read_r(trd), .t_write_r(twr),
    .t_inhibit_r(t_inh), .t_sense(t_sen), .static_addr_r(st_a),
    .static_rd_r(st_rd), .static_data(st_d));

  cme_far_model far (.clk(clk), .xf_grid(xfg), .xf_reg(xfr), .xs_grid(xsg),
    .xs_reg(xsr), .yf_grid(yfg), .yf_reg(yfr), .ys_grid(ysg), .ys_reg(ysr),
    .s_inhibit(s_inh), .s_sense(s_sen), .t_x_sel(txs), .t_y_sel(tys),
    .t_bank_u(tbu), .t_read(trd), .t_write(twr), .t_inhibit(t_inh),
    .t_sense(t_sen), .static_addr(st_a), .static_rd(st_rd),
    .static_data(st_d));

  initial clk = 1'b0;
  always #(CLK_NS / 2.0) clk = ~clk;

  task automatic note(input string msg);
    fails++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : note

  task automatic tally_and_finish;
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic cmp_buf(input logic [W-1:0] e, input logic [W-1:0] m);
    checked++;
    if ((memory_buffer_reg & m) !== (e & m)) note("buffer word differs");
  endtask : cmp_buf

  task automatic cmp_opd(input logic [FF_W-1:0] e);
    checked++;
    if (operand_reg !== e) note("operand word differs");
  endtask : cmp_opd

  task automatic cmp_ps(input logic e);
    checked++;
    if (parity_skip_r !== e) note("parity skip differs");
  endtask : cmp_ps

  task automatic cmp_busy(input logic e);
    checked++;
    if (busy_r !== e) note("busy level differs");
  endtask : cmp_busy

  // One access: note the result, hold req one cycle, wait for done.
  // A poke raises req mid-access; it must be ignored, so no extra done.
  task automatic acc(input cme_mem_t m, input logic st,
                     input logic [15:0] ad, input logic [W-1:0] wd,
                     input logic [1:0] k, input logic [W-1:0] ev,
                     input logic [W-1:0] mk, input logic poke);
    cme_note_t n;
    bit got;
    n.kind = k;
    n.val = ev;
    n.msk = mk;
    n.pchk = (m == CME_MEM_V);
    q.push_back(n);
    mem_sel = m;
    store = st;
    addr = ad;
    wdata = wd;
    req = 1'b1;
    @(negedge clk) req = 1'b0;
    cmp_busy(1'b1);
    if (poke) begin
      repeat (10) @(negedge clk);
      req = 1'b1;
      store = ~st;
      @(negedge clk) req = 1'b0;
    end
    got = 0;
    for (int i = 0; i < 400 && !got; i++) begin
      @(negedge clk);
      got = (done_r === 1'b1);
    end
    if (!got) note("no done");
  endtask : acc

  // Every done retires the oldest note
  always @(negedge clk) begin
    if (done_r === 1'b1) begin
      if (q.size() == 0) note("done without request");
      else begin
        automatic cme_note_t n = q.pop_front();
        if (n.kind == KB) cmp_buf(n.val, n.msk);
        if (n.kind == KO) cmp_opd(n.val[FF_W-1:0]);
        cmp_ps(n.pchk);
        cmp_busy(1'b0);
      end
    end
  end

  initial begin
    rst_n = 1'b0;
    req = 1'b0;
    store = 1'b0;
    mem_sel = CME_MEM_S;
    addr = '0;
    wdata = '0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    // Large core: store, read, read again after write-back
    for (int i = 0; i < 3; i++) begin
      a = 16'($random(seed));
      d = W'({$random(seed), $random(seed)});
      acc(CME_MEM_S, 1'b1, a, d, KB, d, ALL, 1'b0);
      acc(CME_MEM_S, 1'b0, a, '0, KB, d, ALL, 1'b0);
      acc(CME_MEM_S, 1'b0, a, '0, KB, d, ALL, 1'b0);
    end
    // Small and reserved banks at one address stay apart
    for (int i = 0; i < 2; i++) begin
      a = 16'($random(seed)) & 16'h0fff;
      d = W'({$random(seed), $random(seed)});
      d2 = W'({$random(seed), $random(seed)});
      acc(CME_MEM_T, 1'b1, a, d, KB, d, ALL, 1'b0);
      acc(CME_MEM_U, 1'b1, a, d2, KB, d2, ALL, 1'b0);
      acc(CME_MEM_T, 1'b0, a, '0, KB, d, ALL, 1'b1);
      acc(CME_MEM_U, 1'b0, a, '0, KB, d2, ALL, 1'b0);
    end
    // Register section: four stores, then reads, then empty slots
    for (int r = 0; r < 4; r++) begin
      rd[r] = W'({$random(seed), $random(seed)});
      acc(CME_MEM_V, 1'b1, 16'(r), rd[r], KN, '0, ALL, 1'b0);
    end
    for (int r = 3; r >= 0; r--)
      acc(CME_MEM_V, 1'b0, 16'(r), '0, KO, rd[r], ALL, 1'b0);
    acc(CME_MEM_V, 1'b1, 16'h0006, ALL, KN, '0, ALL, 1'b0);
    acc(CME_MEM_V, 1'b0, 16'h0006, '0, KO, '0, ALL, 1'b0);
    acc(CME_MEM_V, 1'b0, 16'h0005, '0, KO, '0, ALL, 1'b0);
    // Static section whenever the selector bits are not all zero
    for (int i = 0; i < 7; i++) begin
      a = 16'($random(seed));
      a[6:4] = 3'(i + 1);
      d = W'(ST_W'({4{a[8:0]}}) ^ 37'h05a5a5a5a5);
      acc(CME_MEM_V, 1'b0, a, '0, KB, d, SMSK, 1'b0);
    end
    // Let the watcher retire the last note before the queue is judged
    repeat (2) @(negedge clk);
    if (q.size() != 0) note("missing done");
    tally_and_finish();
  end

  // Watchdog well beyond the roughly 4100 cycles of the sequence
  initial begin
    #(CLK_NS * 40000);
    note("watchdog");
    tally_and_finish();
  end
endmodule : tb_cme_ctrl
